// file: common/scd_pkg.sv
// Constants, field layouts and carrier types of the sensor coefficient decoder
// Functional notes
// [RULE_01] Host computes all coefficients externally and writes them into the store.
// [RULE_02] Raw bridge sample is unsigned 0..16383, one count per step.
// [RULE_03] Raw temperature sample is unsigned 0..16383, four counts per step.
// [RULE_04] Bridge gain bit 14 set multiplies the lower fourteen gain bits by 8.
// [RULE_05] Bridge gain bits 13:0 are a fraction in [0,8), bit 13 weighs 4.
// [RULE_06] Bridge offset is 14-bit unsigned, top bit 8192, bit 0 weighs 1.
// [RULE_07] Temperature gain is 8-bit fraction 0..2, bit 7 weighs 1.
// [RULE_08] Temperature offset is 8-bit two's complement, top bit weighs -128.
// [RULE_09] Offset drift term is magnitude plus sign, times 8 when scale flag set.
// [RULE_10] Gain drift term is 8-bit magnitude plus sign, never scaled.
// [RULE_11] Second-order term acts on exactly one target chosen by a two-bit selector.
// [RULE_12] Offset target with scale flag: both offset drift and second-order part times 8.
// [RULE_13] Bridge nonlinearity correction saturates, never wraps, beyond -25% of full scale.
// [RULE_14] Calibration reference holds upper 7 bits of raw temperature at low point.
// [RULE_15] Selector 00 bridge, 01 gain drift, 10 offset drift, 11 prohibited.
// [RULE_16] Second-order term is sign-magnitude: bit 7 negative, bits 6:0 magnitude.
// [RULE_17] Drift config bit 0 negates offset term, bit 1 scales it, bit 2 negates gain.
// [RULE_18] All coefficients leave as signed fixed point with guard bits for scaling.
package scd_pkg;

   // Bus geometry
   localparam int SCD_ADDR_W = 8;
   localparam int SCD_DATA_W = 32;
   localparam int SCD_NCFG = 4;
   localparam logic [1:0] SCD_RESP_OKAY = 2'h0;
   localparam logic [1:0] SCD_RESP_SLVERR = 2'h2;

   // Register byte addresses
   localparam logic [SCD_ADDR_W-1:0] SCD_BRIDGE_CFG = 8'h00;
   localparam logic [SCD_ADDR_W-1:0] SCD_THERM_CFG = 8'h04;
   localparam logic [SCD_ADDR_W-1:0] SCD_DRIFT_CFG = 8'h08;
   localparam logic [SCD_ADDR_W-1:0] SCD_SECOND_CFG = 8'h0C;
   localparam logic [SCD_ADDR_W-1:0] SCD_STATUS = 8'h10;
   localparam logic [SCD_ADDR_W-1:0] SCD_GAIN_RD = 8'h14;
   localparam logic [SCD_ADDR_W-1:0] SCD_DRIFT_RD = 8'h18;
   localparam logic [SCD_ADDR_W-1:0] SCD_SAMPLE_RD = 8'h1C;

   // Writable bit masks; reserved bits read as zero
   localparam logic [31:0] SCD_BRIDGE_MASK = 32'h3FFF7FFF;
   localparam logic [31:0] SCD_THERM_MASK = 32'h017FFFFF;
   localparam logic [31:0] SCD_DRIFT_MASK = 32'h0007FFFF;
   localparam logic [31:0] SCD_SECOND_MASK = 32'h000003FF;

   // Field positions
   localparam int SCD_GAINB_LSB = 0;
   localparam int SCD_OFFB_LSB = 16;
   localparam int SCD_GAINT_LSB = 0;
   localparam int SCD_OFFT_LSB = 8;
   localparam int SCD_TREF_LSB = 16;
   localparam int SCD_EXTSEL_BIT = 24;
   localparam int SCD_TCG_LSB = 0;
   localparam int SCD_TCO_LSB = 8;
   localparam int SCD_TCCFG_LSB = 16;
   localparam int SCD_SOT_LSB = 0;
   localparam int SCD_SEL_LSB = 8;

   // Coefficient encodings
   localparam int SCD_GAIN_SCALE_BIT = 14;
   localparam int SCD_TCO_NEG_BIT = 0;
   localparam int SCD_TCO_SCALE_BIT = 1;
   localparam int SCD_TCG_NEG_BIT = 2;
   localparam int SCD_SOT_SIGN_BIT = 7;
   localparam int SCD_SCALE_SHIFT = 3;
   localparam int SCD_TEMP_STEP_SHIFT = 2;
   localparam int SCD_TREF_SHIFT = 5;
   localparam int SCD_SQ_SHIFT = 14;
   localparam int SCD_NL_SHIFT = 9;
   localparam logic signed [15:0] SCD_NL_LIMIT = 16'sh1000;
   localparam logic signed [15:0] SCD_FULL_SCALE = 16'sh3FFF;

   // Second-order target selection
   typedef enum logic [1:0] {
      SCD_TGT_BRIDGE,
      SCD_TGT_GAIN_DRIFT,
      SCD_TGT_OFFSET_DRIFT,
      SCD_TGT_PROHIBITED
   } scd_target_t;

   // Decoded coefficients and samples handed to the correction arithmetic
   typedef struct packed {
      logic signed [17:0] gain_b;
      logic signed [14:0] offset_b;
      logic signed [8:0] gain_t;
      logic signed [8:0] offset_t;
      logic signed [11:0] offset_drift;
      logic signed [8:0] gain_drift;
      logic signed [10:0] sot_offset_drift;
      logic signed [7:0] sot_gain_drift;
      logic signed [7:0] sot_bridge;
      logic [13:0] bridge;
      logic [11:0] temp;
      logic signed [12:0] temp_delta;
      logic [13:0] bridge_lin;
      logic nl_saturated;
      logic target_bad;
   } scd_coeff_t;

   // Whole state of the decoder
   typedef struct packed {
      logic [SCD_NCFG-1:0][31:0] cfg;
      logic awready;
      logic wready;
      logic aw_held;
      logic w_held;
      logic [SCD_ADDR_W-1:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      scd_coeff_t dec;
   } scd_state_t;

endpackage

// file: hw/scd_decoder.sv
// Coefficient decoder with AXI4-Lite register access
//
// Local design decisions: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
module scd_decoder
   import scd_pkg::*;
(
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic [SCD_ADDR_W-1:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [SCD_ADDR_W-1:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   input wire logic [13:0] bridge_raw_sample_i,
   input wire logic [13:0] internal_thermal_raw_i,
   input wire logic [13:0] external_thermal_raw_i,
   output scd_coeff_t coeff_o
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   scd_state_t st;
   scd_state_t next_st;

   // Stored fields as seen by the decode logic
   logic [14:0] gain_b_raw;
   logic [13:0] offset_b_raw;
   logic [7:0] gain_t_raw;
   logic [7:0] offset_t_raw;
   logic [6:0] cal_low_temp_ref;
   logic ext_temp_sel;
   logic [7:0] tcg_mag;
   logic [7:0] tco_mag;
   logic [2:0] drift_comp_config;
   logic [7:0] second_order_coeff;
   scd_target_t second_order_target_sel;

   // Decode intermediates
   logic [16:0] gain_mag;
   logic [10:0] tco_scaled;
   logic signed [7:0] sot_signed;
   logic signed [10:0] sot_scaled;
   logic [13:0] temp_raw;
   logic [27:0] bridge_sq;
   logic signed [22:0] nl_prod;
   logic signed [15:0] nl_corr;
   logic signed [15:0] nl_sum;
   scd_coeff_t dec;

   // ----------------------------------------------------------------
   // Field extraction
   // ----------------------------------------------------------------
   // Software-written coefficient image, already computed by the host [RULE_01]
   assign gain_b_raw = st.cfg[0][SCD_GAINB_LSB +: 15];
   assign offset_b_raw = st.cfg[0][SCD_OFFB_LSB +: 14];
   assign gain_t_raw = st.cfg[1][SCD_GAINT_LSB +: 8];
   assign offset_t_raw = st.cfg[1][SCD_OFFT_LSB +: 8];
   assign cal_low_temp_ref = st.cfg[1][SCD_TREF_LSB +: 7];
   assign ext_temp_sel = st.cfg[1][SCD_EXTSEL_BIT];
   assign tcg_mag = st.cfg[2][SCD_TCG_LSB +: 8];
   assign tco_mag = st.cfg[2][SCD_TCO_LSB +: 8];
   assign drift_comp_config = st.cfg[2][SCD_TCCFG_LSB +: 3];
   assign second_order_coeff = st.cfg[3][SCD_SOT_LSB +: 8];
   assign second_order_target_sel = scd_target_t'(st.cfg[3][SCD_SEL_LSB +: 2]);

   // ----------------------------------------------------------------
   // Coefficient decode
   // ----------------------------------------------------------------
   // Scale options widen the value, so guard bits keep every product in range
   always_comb
   begin
      dec = '0;
      // Gain in Q6.11: bit 13 weighs 4, bit 0 weighs 2^-11 [RULE_05]
      if (gain_b_raw[SCD_GAIN_SCALE_BIT])
         gain_mag = {gain_b_raw[13:0], 3'h0}; // Times 8, range up to 64 [RULE_04]
      else
         gain_mag = {3'h0, gain_b_raw[13:0]};
      dec.gain_b = $signed({1'b0, gain_mag}); // [RULE_18]
      dec.offset_b = $signed({1'b0, offset_b_raw}); // Integer, top bit 8192 [RULE_06]
      dec.gain_t = $signed({1'b0, gain_t_raw}); // Q1.7, bit 7 weighs 1 [RULE_07]
      dec.offset_t = $signed({offset_t_raw[7], offset_t_raw}); // [RULE_08]

      // Offset drift: magnitude, sign from bit 0, scale from bit 1 [RULE_09] [RULE_17]
      if (drift_comp_config[SCD_TCO_SCALE_BIT])
         tco_scaled = {tco_mag, 3'h0};
      else
         tco_scaled = {3'h0, tco_mag};
      if (drift_comp_config[SCD_TCO_NEG_BIT])
         dec.offset_drift = -$signed({1'b0, tco_scaled});
      else
         dec.offset_drift = $signed({1'b0, tco_scaled});

      // Gain drift: magnitude with sign from bit 2, no scaling [RULE_10] [RULE_17]
      if (drift_comp_config[SCD_TCG_NEG_BIT])
         dec.gain_drift = -$signed({1'b0, tcg_mag});
      else
         dec.gain_drift = $signed({1'b0, tcg_mag});

      // Second-order term in sign-magnitude form [RULE_16]
      if (second_order_coeff[SCD_SOT_SIGN_BIT])
         sot_signed = -$signed({1'b0, second_order_coeff[6:0]});
      else
         sot_signed = $signed({1'b0, second_order_coeff[6:0]});
      sot_scaled = 11'(sot_signed);
      if (drift_comp_config[SCD_TCO_SCALE_BIT])
         sot_scaled = sot_scaled <<< SCD_SCALE_SHIFT; // Follows offset drift scale [RULE_12]

      // Exactly one target receives the term; prohibited code gives none [RULE_11]
      case (second_order_target_sel)
         SCD_TGT_BRIDGE: dec.sot_bridge = sot_signed; // [RULE_15]
         SCD_TGT_GAIN_DRIFT: dec.sot_gain_drift = sot_signed; // [RULE_15]
         SCD_TGT_OFFSET_DRIFT: dec.sot_offset_drift = sot_scaled; // [RULE_15]
         default: dec.target_bad = 1'b1; // [RULE_15]
      endcase

      // Raw samples: bridge in counts, temperature in steps of four counts
      dec.bridge = bridge_raw_sample_i; // [RULE_02]
      temp_raw = ext_temp_sel ? external_thermal_raw_i : internal_thermal_raw_i;
      dec.temp = temp_raw[13:SCD_TEMP_STEP_SHIFT]; // [RULE_03]

      // Temperature measured from the calibration low point [RULE_14]
      dec.temp_delta = $signed({1'b0, dec.temp})
         - $signed({1'b0, cal_low_temp_ref, 5'h00});

      // Bridge nonlinearity: b^2 normalised to full scale, times the term
      bridge_sq = bridge_raw_sample_i * bridge_raw_sample_i;
      nl_prod = dec.sot_bridge * $signed({1'b0, bridge_sq[27:SCD_SQ_SHIFT]});
      nl_corr = 16'(nl_prod >>> SCD_NL_SHIFT);
      // Clamp the correction instead of letting it wrap [RULE_13]
      if (nl_corr < -SCD_NL_LIMIT)
      begin
         nl_corr = -SCD_NL_LIMIT;
         dec.nl_saturated = 1'b1;
      end
      nl_sum = $signed({2'h0, bridge_raw_sample_i}) + nl_corr;
      // Result held inside the output code range [RULE_13]
      if (nl_sum < 16'sh0000)
      begin
         dec.bridge_lin = '0;
         dec.nl_saturated = 1'b1;
      end
      else if (nl_sum > SCD_FULL_SCALE)
      begin
         dec.bridge_lin = SCD_FULL_SCALE[13:0];
         dec.nl_saturated = 1'b1;
      end
      else
      begin
         dec.bridge_lin = nl_sum[13:0];
      end
   end

   // ----------------------------------------------------------------
   // Next state: bus slave and decode register
   // ----------------------------------------------------------------
   // Write address and data are taken in either order; response follows both
   always_comb
   begin
      logic [31:0] mask;
      logic [31:0] merged;
      logic [SCD_ADDR_W-1:0] raddr;
      mask = '0;
      merged = '0;
      raddr = s_axi_araddr_i;
      next_st = st;
      next_st.dec = dec;

      if (s_axi_awvalid_i && st.awready)
      begin
         next_st.aw_held = 1'b1;
         next_st.awaddr = s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && st.wready)
      begin
         next_st.w_held = 1'b1;
         next_st.wdata = s_axi_wdata_i;
         next_st.wstrb = s_axi_wstrb_i;
      end
      if (st.bvalid && s_axi_bready_i)
         next_st.bvalid = 1'b0;

      // Commit once both halves are held and the last response is gone
      if (st.aw_held && st.w_held && !st.bvalid)
      begin
         case (st.awaddr)
            SCD_BRIDGE_CFG: mask = SCD_BRIDGE_MASK;
            SCD_THERM_CFG: mask = SCD_THERM_MASK;
            SCD_DRIFT_CFG: mask = SCD_DRIFT_MASK;
            SCD_SECOND_CFG: mask = SCD_SECOND_MASK;
            default: mask = '0;
         endcase
         merged = st.cfg[st.awaddr[3:2]];
         for (int b = 0; b < 4; b++)
         begin
            if (st.wstrb[b])
               merged[8*b +: 8] = st.wdata[8*b +: 8];
         end
         if (mask != '0) // Unmapped or unaligned offsets store nothing
            next_st.cfg[st.awaddr[3:2]] = merged & mask;
         case (st.awaddr)
            SCD_BRIDGE_CFG, SCD_THERM_CFG, SCD_DRIFT_CFG, SCD_SECOND_CFG,
            SCD_STATUS, SCD_GAIN_RD, SCD_DRIFT_RD, SCD_SAMPLE_RD:
               next_st.bresp = SCD_RESP_OKAY;
            default: next_st.bresp = SCD_RESP_SLVERR;
         endcase
         next_st.bvalid = 1'b1;
         next_st.aw_held = 1'b0;
         next_st.w_held = 1'b0;
      end
      next_st.awready = !next_st.aw_held;
      next_st.wready = !next_st.w_held;

      // Read path: one read under way, answered the cycle after it is taken
      if (st.rvalid && s_axi_rready_i)
         next_st.rvalid = 1'b0;
      if (s_axi_arvalid_i && st.arready)
      begin
         next_st.rvalid = 1'b1;
         next_st.rresp = SCD_RESP_OKAY;
         case (raddr)
            SCD_BRIDGE_CFG: next_st.rdata = st.cfg[0];
            SCD_THERM_CFG: next_st.rdata = st.cfg[1];
            SCD_DRIFT_CFG: next_st.rdata = st.cfg[2];
            SCD_SECOND_CFG: next_st.rdata = st.cfg[3];
            SCD_STATUS: next_st.rdata = {30'h0, st.dec.nl_saturated, st.dec.target_bad};
            SCD_GAIN_RD: next_st.rdata = 32'(st.dec.gain_b);
            SCD_DRIFT_RD:
               next_st.rdata = {7'h00, st.dec.gain_drift, 4'h0, st.dec.offset_drift};
            SCD_SAMPLE_RD:
               next_st.rdata = {3'h0, st.dec.temp_delta, 2'h0, st.dec.bridge_lin};
            default:
            begin
               next_st.rdata = '0;
               next_st.rresp = SCD_RESP_SLVERR;
            end
         endcase
      end
      next_st.arready = !next_st.rvalid;

      if (sys_rst_i)
         next_st = '0;
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   // Synchronous reset folded into next state
   always_ff @(posedge mclk_i)
   begin
      st <= next_st;
   end

   // Outputs straight from state flip-flops
   assign s_axi_awready_o = st.awready;
   assign s_axi_wready_o = st.wready;
   assign s_axi_bresp_o = st.bresp;
   assign s_axi_bvalid_o = st.bvalid;
   assign s_axi_arready_o = st.arready;
   assign s_axi_rdata_o = st.rdata;
   assign s_axi_rresp_o = st.rresp;
   assign s_axi_rvalid_o = st.rvalid;
   assign coeff_o = st.dec;

endmodule // scd_decoder
`default_nettype wire

// file: testbench/scd_sensor_model.sv
// Sensor front end model that hands raw samples to the decoder
`timescale 1ns/1ns
`default_nettype none
module scd_sensor_model (
   input wire logic mclk_i,
   input wire logic [13:0] bridge_set_i,
   input wire logic [13:0] int_set_i,
   input wire logic [13:0] ext_set_i,
   output logic [13:0] bridge_raw_sample_o,
   output logic [13:0] internal_thermal_raw_o,
   output logic [13:0] external_thermal_raw_o
);
   // Converter results land one clock after the level is set
   always_ff @(posedge mclk_i)
   begin
      bridge_raw_sample_o <= bridge_set_i;
      internal_thermal_raw_o <= int_set_i;
      external_thermal_raw_o <= ext_set_i;
   end
endmodule // scd_sensor_model
`default_nettype wire

// file: testbench/scd_check_assertions.sv
// Port checker for the coefficient decoder
`timescale 1ns/1ns
`default_nettype none
module scd_check
   import scd_pkg::*;
(
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic s_axi_awvalid_i,
   input wire logic s_axi_awready_o,
   input wire logic s_axi_arvalid_i,
   input wire logic s_axi_arready_o,
   input wire logic s_axi_rvalid_o,
   input wire logic s_axi_bvalid_o,
   input wire logic [13:0] bridge_raw_sample_i,
   input wire logic [13:0] internal_thermal_raw_i,
   input wire logic [13:0] external_thermal_raw_i,
   input wire scd_coeff_t coeff_o
);
   scd_coeff_t c;
   // -----------------------------
   // Decoded value relations and bus answer timing
   // -----------------------------
   assign c = coeff_o;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);
   property p_gain; c.gain_b < 18'sh04000 || c.gain_b[2:0] == 3'h0; endproperty
   property p_unsig; !c.gain_t[8] && !c.offset_b[14] && !c.gain_b[17]; endproperty
   property p_offt; c.offset_t[8] == c.offset_t[7]; endproperty
   property p_tco; c.offset_drift > 12'sh0FF |-> c.offset_drift[2:0] == 3'h0; endproperty
   property p_tcg; c.gain_drift != 9'sh100; endproperty
   property p_one; $countones({|c.sot_bridge, |c.sot_gain_drift, |c.sot_offset_drift}) < 2;
   endproperty
   property p_bad; c.target_bad |-> !(|{c.sot_bridge, c.sot_gain_drift, c.sot_offset_drift});
   endproperty
   property p_sot; c.sot_bridge != 8'sh80 && c.sot_gain_drift != 8'sh80; endproperty
   property p_raw; !$past(sys_rst_i) |-> c.bridge == $past(bridge_raw_sample_i); endproperty
   property p_temp; !$past(sys_rst_i) |-> c.temp == $past(internal_thermal_raw_i) >> 2
      || c.temp == $past(external_thermal_raw_i) >> 2; endproperty
   property p_lin; int'(c.bridge_lin) + 4096 >= int'(c.bridge); endproperty
   property p_rd; s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o; endproperty
   property p_wr; s_axi_awvalid_i && s_axi_awready_o |-> ##[1:8] s_axi_bvalid_o; endproperty
   a_gain: assert property (p_gain) else $error("gain scale");
   a_unsig: assert property (p_unsig) else $error("sign");
   a_offt: assert property (p_offt) else $error("offset_t");
   a_tco: assert property (p_tco) else $error("tco scale");
   a_tcg: assert property (p_tcg) else $error("tcg");
   a_one: assert property (p_one) else $error("targets");
   a_bad: assert property (p_bad) else $error("bad sel");
   a_sot: assert property (p_sot) else $error("sot");
   a_raw: assert property (p_raw) else $error("bridge");
   a_temp: assert property (p_temp) else $error("temp");
   a_lin: assert property (p_lin) else $error("lin");
   a_rd: assert property (p_rd) else $error("read answer");
   a_wr: assert property (p_wr) else $error("write answer");
   c_bad: cover property (c.target_bad);
   c_tco: cover property (c.offset_drift < -12'sh0FF);
   c_wr: cover property (s_axi_bvalid_o);
endmodule // scd_check
bind scd_decoder scd_check chk_u (.mclk_i, .sys_rst_i, .s_axi_awvalid_i, .s_axi_awready_o,
   .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rvalid_o, .s_axi_bvalid_o,
   .bridge_raw_sample_i, .internal_thermal_raw_i, .external_thermal_raw_i, .coeff_o);
`default_nettype wire

// file: testbench/test_sensor_coeff_decode.sv
// Self-checking bench for the coefficient decoder
`timescale 1ns/1ns
`default_nettype none
module test_sensor_coeff_decode
   import scd_pkg::*;
();
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
   logic [7:0] awa = 8'h00, ara = 8'h00;
   logic [31:0] wd = 32'h0;
   logic [3:0] ws = 4'h0;
   logic [13:0] bset = 14'h0, iset = 14'h0, eset = 14'h0, braw, iraw, eraw;
   logic awr, wr_rdy, bv, arr, rv;
   logic [1:0] br, rr;
   logic [31:0] rd;
   scd_coeff_t c;
   int err_total = 0, total_checks = 0;
   // Clock
   always #2 mclk = ~mclk;
   scd_sensor_model sm_u (.mclk_i(mclk), .bridge_set_i(bset), .int_set_i(iset),
      .ext_set_i(eset), .bridge_raw_sample_o(braw), .internal_thermal_raw_o(iraw),
      .external_thermal_raw_o(eraw));
   scd_decoder dut_u (.mclk_i(mclk), .sys_rst_i(rst), .s_axi_awaddr_i(awa),
      .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws),
      .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_rdy), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv),
      .s_axi_bready_i(brdy), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
      .s_axi_arready_o(arr), .s_axi_rdata_o(rd), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv),
      .s_axi_rready_i(rrdy), .bridge_raw_sample_i(braw), .internal_thermal_raw_i(iraw),
      .external_thermal_raw_i(eraw), .coeff_o(c));
   // ------------------------
   // Reporting and bus tasks
   // ------------------------
   task automatic results();
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
      total_checks++;
      if (g !== e)
      begin
         err_total++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask
   task automatic hang();
      err_total++;
      $display("CHECK FAILED %0t no answer", $time);
      results();
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge mclk);
   endtask
   // Write with address and data offered together, response awaited
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
      input logic [1:0] e);
      int n;
      @(posedge mclk);
      awa <= a;
      wd <= d;
      ws <= s;
      awv <= 1'b1;
      wv <= 1'b1;
      brdy <= 1'b1;
      for (n = 0; n < 64; n++)
      begin
         @(posedge mclk);
         if (awv && awr)
            awv <= 1'b0;
         if (wv && wr_rdy)
            wv <= 1'b0;
         if (bv)
         begin
            chk({30'h0, br}, {30'h0, e}, "bresp");
            brdy <= 1'b0;
            break;
         end
      end
      if (n == 64)
         hang();
   endtask
   // Read and compare data and response
   task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      int n;
      @(posedge mclk);
      ara <= a;
      arv <= 1'b1;
      rrdy <= 1'b1;
      for (n = 0; n < 64; n++)
      begin
         @(posedge mclk);
         if (arv && arr)
            arv <= 1'b0;
         if (rv)
         begin
            chk(rd, e, "rdata");
            chk({30'h0, rr}, {30'h0, er}, "rresp");
            rrdy <= 1'b0;
            break;
         end
      end
      if (n == 64)
         hang();
   endtask
   // Expected corrected bridge value
   function automatic int nl(int b, int s);
      int v;
      v = (s * ((b * b) >>> 14)) >>> 9;
      if (v < -4096)
         v = -4096;
      v = b + v;
      return v > 16383 ? 16383 : (v < 0 ? 0 : v);
   endfunction
   // ------------------------
   // Scenarios
   // ------------------------
   task automatic t_reset();
      chk(c.gain_b, 0, "gain rst");
      for (int i = 0; i < 4; i++)
         rdc(8'(i * 4), 32'h0, SCD_RESP_OKAY);
   endtask
   task automatic t_bridge();
      logic [14:0] g[5] = '{15'h0000, 15'h2000, 15'h3FFF, 15'h4001, 15'h7FFF};
      int e;
      foreach (g[i])
      begin
         e = g[i][14] ? int'(g[i][13:0]) * 8 : int'(g[i][13:0]);
         wr(8'h00, {2'h0, 14'h3FFF - g[i][13:0], 1'b0, g[i]}, 4'hF, 2'h0);
         tick(3);
         chk(c.gain_b, e, "gain");
         chk(c.offset_b, 14'h3FFF - g[i][13:0], "offset");
         rdc(SCD_GAIN_RD, e, SCD_RESP_OKAY);
      end
   endtask
   task automatic t_therm();
      iset <= 14'h3FFF;
      eset <= 14'h0005;
      wr(SCD_THERM_CFG, 32'h010380FF, 4'hF, SCD_RESP_OKAY);
      tick(3);
      chk(c.gain_t, 255, "gain_t");
      chk(c.offset_t, -128, "offset_t");
      chk(c.temp, 1, "temp ext");
      chk(c.temp_delta, -95, "delta");
      wr(SCD_THERM_CFG, 32'h00037F01, 4'hF, SCD_RESP_OKAY);
      tick(3);
      chk(c.offset_t, 127, "offset_t");
      chk(c.temp, 4095, "temp int");
      chk(c.temp_delta, 3999, "delta");
   endtask
   task automatic t_drift();
      for (int k = 0; k < 8; k++)
      begin
         wr(SCD_DRIFT_CFG, {13'h0, 3'(k), 16'hFFFF}, 4'hF, SCD_RESP_OKAY);
         tick(3);
         chk(c.offset_drift, (k[0] ? -255 : 255) * (k[1] ? 8 : 1), "tco");
         chk(c.gain_drift, k[2] ? -255 : 255, "tcg");
      end
      wr(SCD_DRIFT_CFG, 32'h00000100, 4'h2, SCD_RESP_OKAY);
      tick(3);
      chk(c.offset_drift, -8, "merge");
      chk(c.gain_drift, -255, "merge");
      rdc(SCD_DRIFT_RD, {7'h00, 9'h101, 4'h0, 12'hFF8}, SCD_RESP_OKAY);
   endtask
   task automatic t_second();
      for (int s = 0; s < 4; s++)
      begin
         wr(SCD_SECOND_CFG, {22'h0, 2'(s), 8'h85}, 4'hF, SCD_RESP_OKAY);
         tick(3);
         chk(c.sot_bridge, s == 0 ? -5 : 0, "sotb");
         chk(c.sot_gain_drift, s == 1 ? -5 : 0, "sotg");
         chk(c.sot_offset_drift, s == 2 ? -40 : 0, "soto");
         rdc(SCD_STATUS, {31'h0, s == 3}, SCD_RESP_OKAY);
      end
   endtask
   task automatic t_lin();
      logic [13:0] bs[3] = '{14'h3FFF, 14'h2000, 14'h0001};
      logic [7:0] so[3] = '{8'h7F, 8'hFF, 8'h40};
      int s;
      foreach (bs[i])
      begin
         s = so[i][7] ? -int'(so[i][6:0]) : int'(so[i][6:0]);
         bset <= bs[i];
         wr(SCD_SECOND_CFG, {24'h0, so[i]}, 4'hF, SCD_RESP_OKAY);
         tick(3);
         chk(c.bridge, bs[i], "raw");
         chk(c.bridge_lin, nl(bs[i], s), "lin");
         rdc(SCD_SAMPLE_RD, {3'h0, 13'h0F9F, 2'h0, 14'(nl(bs[i], s))},
            SCD_RESP_OKAY);
         rdc(SCD_STATUS, {30'h0, i == 0, 1'b0}, SCD_RESP_OKAY);
      end
   endtask
   task automatic t_bus();
      wr(8'h20, 32'hFFFFFFFF, 4'hF, SCD_RESP_SLVERR);
      rdc(8'h20, 32'h0, SCD_RESP_SLVERR);
      wr(SCD_STATUS, 32'hFFFFFFFF, 4'hF, SCD_RESP_OKAY);
      wr(SCD_BRIDGE_CFG, 32'hFFFFFFFF, 4'hF, SCD_RESP_OKAY);
      rdc(SCD_BRIDGE_CFG, SCD_BRIDGE_MASK, SCD_RESP_OKAY);
      // Unaligned offset is refused and leaves the stored word alone
      wr(8'h01, 32'h00000000, 4'hF, SCD_RESP_SLVERR);
      rdc(SCD_BRIDGE_CFG, SCD_BRIDGE_MASK, SCD_RESP_OKAY);
   endtask
   // Main sequence
   initial
   begin
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      t_reset();
      t_bridge();
      t_therm();
      t_drift();
      t_second();
      t_lin();
      t_bus();
      results();
   end
endmodule // test_sensor_coeff_decode
`default_nettype wire
